// File: hw/motor_startup_brake_config.sv
// Start-up and brake configuration registers with stop and brake timing
`timescale 1ns/1ps
module motor_startup_brake_config
    import motor_cfg_pkg::*;
#(
    parameter int MS_CYCLES = CYCLES_PER_TICK
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register access port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_ack,
    // Motor control events, same clock domain
    input wire logic seq_start,
    input wire logic zero_cross,
    input wire logic brake_request,
    // Applied settings
    output logic [11:0] stationary_ms,
    output logic [11:0] stationary_chz,
    output logic [5:0] brake_current_ma,
    output logic [5:0] backemf_hysteresis_mv,
    output logic speed_detect_enable,
    output logic reverse_drive_enable,
    output logic [8:0] reverse_threshold_dhz,
    output logic [10:0] openloop_current_ma,
    output logic [10:0] align_current_ma,
    output logic [12:0] openloop_current_ramp,
    output logic [11:0] brake_time_ms,
    output logic brake_active_flag,
    output logic accel_range_select,
    // Sequencing status
    output logic rotor_stopped,
    output logic braking,
    output logic brake_done
);

    logic [15:0] brake_cfg_q;
    logic [15:0] accel_cfg_q;
    logic [15:0] brake_act_q;
    logic [15:0] accel_act_q;
    logic [15:0] rdata_q;
    logic ack_q;
    logic [31:0] tick_cnt_q;
    logic ms_tick_q;
    logic [11:0] idle_ms_q;
    logic stopped_q;
    logic braking_q;
    logic [11:0] brake_ms_q;
    logic brake_done_q;

    // Software-visible registers
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            brake_cfg_q <= RESET_STARTUP_BRAKE;
            accel_cfg_q <= RESET_ACCEL_THRESHOLD;
        end
        else if (reg_wr)
        begin
            if (reg_addr == ADDR_STARTUP_BRAKE)
            begin
                brake_cfg_q <= reg_wdata;
            end
            if (reg_addr == ADDR_ACCEL_THRESHOLD)
            begin
                accel_cfg_q <= reg_wdata & ACCEL_WRITE_MASK;
            end
        end
    end

    // Read data, unmapped addresses read zero
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            rdata_q <= 16'h0000;
            ack_q <= 1'b0;
        end
        else
        begin
            ack_q <= reg_wr | reg_rd;
            if (reg_rd)
            begin
                if (reg_addr == ADDR_STARTUP_BRAKE)
                begin
                    rdata_q <= brake_cfg_q;
                end
                else if (reg_addr == ADDR_ACCEL_THRESHOLD)
                begin
                    rdata_q <= accel_cfg_q & ACCEL_WRITE_MASK;
                end
                else
                begin
                    rdata_q <= 16'h0000;
                end
            end
        end
    end

    // Applied copies, taken over at sequence start
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            brake_act_q <= RESET_STARTUP_BRAKE;
            accel_act_q <= RESET_ACCEL_THRESHOLD;
        end
        else if (seq_start)
        begin
            brake_act_q <= brake_cfg_q;
            accel_act_q <= accel_cfg_q;
        end
    end

    startup_setting_decode decode_inst (
        .sys_clk(sys_clk),
        .rst(rst),
        .brake_cfg(brake_act_q),
        .accel_cfg(accel_act_q),
        .stationary_ms(stationary_ms),
        .stationary_chz(stationary_chz),
        .brake_current_ma(brake_current_ma),
        .backemf_hysteresis_mv(backemf_hysteresis_mv),
        .speed_detect_enable(speed_detect_enable),
        .reverse_drive_enable(reverse_drive_enable),
        .reverse_threshold_dhz(reverse_threshold_dhz),
        .openloop_current_ma(openloop_current_ma),
        .align_current_ma(align_current_ma),
        .openloop_current_ramp(openloop_current_ramp),
        .brake_time_ms(brake_time_ms),
        .brake_active_flag(brake_active_flag),
        .accel_range_select(accel_range_select)
    );

    // Millisecond tick
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            tick_cnt_q <= 32'h0000_0000;
            ms_tick_q <= 1'b0;
        end
        else if (tick_cnt_q >= 32'(MS_CYCLES - 1))
        begin
            tick_cnt_q <= 32'h0000_0000;
            ms_tick_q <= 1'b1;
        end
        else
        begin
            tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
            ms_tick_q <= 1'b0;
        end
    end

    // Stationary judgement: time since last zero cross
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            idle_ms_q <= 12'h000;
            stopped_q <= 1'b0;
        end
        else if (zero_cross)
        begin
            idle_ms_q <= 12'h000;
            stopped_q <= 1'b0;
        end
        else
        begin
            if (ms_tick_q && idle_ms_q != MS_SATURATE)
            begin
                idle_ms_q <= idle_ms_q + 12'h001;
            end
            stopped_q <= (idle_ms_q >= stationary_ms);
        end
    end

    // Brake timer, only when braking is enabled
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            braking_q <= 1'b0;
            brake_ms_q <= 12'h000;
            brake_done_q <= 1'b0;
        end
        else
        begin
            brake_done_q <= 1'b0;
            if (!braking_q)
            begin
                if (brake_request && brake_active_flag)
                begin
                    braking_q <= 1'b1;
                    brake_ms_q <= 12'h000;
                end
            end
            else if (brake_ms_q >= brake_time_ms)
            begin
                braking_q <= 1'b0;
                brake_done_q <= 1'b1;
            end
            else if (ms_tick_q)
            begin
                brake_ms_q <= brake_ms_q + 12'h001;
            end
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_ack = ack_q;
    assign rotor_stopped = stopped_q;
    assign braking = braking_q;
    assign brake_done = brake_done_q;

endmodule : motor_startup_brake_config

// File: hw/motor_cfg_pkg.sv
// Constants for the start-up and brake configuration registers
package motor_cfg_pkg;

    // Register addresses and reset values
    localparam logic [7:0] ADDR_STARTUP_BRAKE = 8'h92;
    localparam logic [7:0] ADDR_ACCEL_THRESHOLD = 8'h93;
    localparam logic [15:0] RESET_STARTUP_BRAKE = 16'h0000;
    localparam logic [15:0] RESET_ACCEL_THRESHOLD = 16'h0000;
    // Bit 15 of the acceleration register is read-only zero
    localparam logic [15:0] ACCEL_WRITE_MASK = 16'h7FFF;

    // Field positions, startup_brake_cfg
    localparam int STAT_THR_LSB = 14;
    localparam int BRAKE_CUR_BIT = 13;
    localparam int HYST_BIT = 12;
    localparam int SPEED_DET_BIT = 11;
    localparam int REV_EN_BIT = 10;
    localparam int REV_THR_LSB = 8;
    localparam int OL_CUR_LSB = 6;
    localparam int RAMP_LSB = 3;
    localparam int BRAKE_SET_LSB = 0;
    // Field positions, startup_accel_threshold_cfg
    localparam int ACCEL_RANGE_BIT = 14;

    // Lookup tables, index is the field code
    localparam logic [11:0] STAT_MS_TABLE [4] =
        '{12'h050, 12'h0A0, 12'h140, 12'h280};
    localparam logic [11:0] STAT_CHZ_TABLE [4] =
        '{12'h258, 12'h12C, 12'h0A0, 12'h050};
    localparam logic [5:0] BRAKE_CUR_MA_LO = 6'h18;
    localparam logic [5:0] BRAKE_CUR_MA_HI = 6'h30;
    localparam logic [5:0] HYST_MV_LO = 6'h14;
    localparam logic [5:0] HYST_MV_HI = 6'h28;
    // Reverse threshold in units of 0.1 Hz
    localparam logic [8:0] REV_THR_DHZ_TABLE [4] =
        '{9'h03F, 9'h082, 9'h104, 9'h1FE};
    localparam logic [10:0] OL_CUR_MA_TABLE [4] =
        '{11'h0C8, 11'h190, 11'h320, 11'h640};
    localparam logic [10:0] ALIGN_CUR_MA_TABLE [4] =
        '{11'h096, 11'h12C, 11'h258, 11'h4B0};
    // Ramp in thousandths of supply per second
    localparam logic [12:0] RAMP_TABLE [8] =
        '{13'h1770, 13'h0BB8, 13'h05DC, 13'h02BC,
          13'h0154, 13'h00A0, 13'h0046, 13'h0017};
    // Brake time in ms; code 0 means no brake
    localparam logic [11:0] BRAKE_MS_TABLE [8] =
        '{12'h000, 12'hA8C, 12'h514, 12'h29E,
          12'h14A, 12'h0A0, 12'h050, 12'h028};

    // Timing
    localparam int CLK_HZ = 40_000_000;
    localparam int TICK_TIME_MS = 1;
    localparam int CYCLES_PER_TICK = CLK_HZ / 1000 * TICK_TIME_MS;
    localparam logic [11:0] MS_SATURATE = 12'hFFF;

endpackage : motor_cfg_pkg

// File: hw/startup_setting_decode.sv
// Registered decode of the applied configuration fields
`timescale 1ns/1ps
module startup_setting_decode
    import motor_cfg_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Applied register images
    input wire logic [15:0] brake_cfg,
    input wire logic [15:0] accel_cfg,
    // Decoded settings
    output logic [11:0] stationary_ms,
    output logic [11:0] stationary_chz,
    output logic [5:0] brake_current_ma,
    output logic [5:0] backemf_hysteresis_mv,
    output logic speed_detect_enable,
    output logic reverse_drive_enable,
    output logic [8:0] reverse_threshold_dhz,
    output logic [10:0] openloop_current_ma,
    output logic [10:0] align_current_ma,
    output logic [12:0] openloop_current_ramp,
    output logic [11:0] brake_time_ms,
    output logic brake_active_flag,
    output logic accel_range_select
);

    logic [1:0] stat_code;
    logic [1:0] rev_code;
    logic [1:0] cur_code;
    logic [2:0] ramp_code;
    logic [2:0] brake_code;

    assign stat_code = brake_cfg[STAT_THR_LSB +: 2];
    assign rev_code = brake_cfg[REV_THR_LSB +: 2];
    assign cur_code = brake_cfg[OL_CUR_LSB +: 2];
    assign ramp_code = brake_cfg[RAMP_LSB +: 3];
    assign brake_code = brake_cfg[BRAKE_SET_LSB +: 3];

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            stationary_ms <= STAT_MS_TABLE[0];
            stationary_chz <= STAT_CHZ_TABLE[0];
            brake_current_ma <= BRAKE_CUR_MA_LO;
            backemf_hysteresis_mv <= HYST_MV_LO;
            speed_detect_enable <= 1'b0;
            reverse_drive_enable <= 1'b0;
            reverse_threshold_dhz <= REV_THR_DHZ_TABLE[0];
            openloop_current_ma <= OL_CUR_MA_TABLE[0];
            align_current_ma <= ALIGN_CUR_MA_TABLE[0];
            openloop_current_ramp <= RAMP_TABLE[0];
            brake_time_ms <= BRAKE_MS_TABLE[0];
            brake_active_flag <= 1'b0;
            accel_range_select <= 1'b0;
        end
        else
        begin
            stationary_ms <= STAT_MS_TABLE[stat_code];
            stationary_chz <= STAT_CHZ_TABLE[stat_code];
            brake_current_ma <= brake_cfg[BRAKE_CUR_BIT] ?
                BRAKE_CUR_MA_HI : BRAKE_CUR_MA_LO;
            backemf_hysteresis_mv <= brake_cfg[HYST_BIT] ?
                HYST_MV_HI : HYST_MV_LO;
            speed_detect_enable <= brake_cfg[SPEED_DET_BIT];
            reverse_drive_enable <= brake_cfg[REV_EN_BIT];
            reverse_threshold_dhz <= REV_THR_DHZ_TABLE[rev_code];
            openloop_current_ma <= OL_CUR_MA_TABLE[cur_code];
            align_current_ma <= ALIGN_CUR_MA_TABLE[cur_code];
            openloop_current_ramp <= RAMP_TABLE[ramp_code];
            brake_time_ms <= BRAKE_MS_TABLE[brake_code];
            brake_active_flag <= (brake_code != 3'b000);
            accel_range_select <= accel_cfg[ACCEL_RANGE_BIT];
        end
    end

endmodule : startup_setting_decode

// File: tb/motor_startup_brake_config_chk.sv
// Port checker for the start-up and brake configuration block
`timescale 1ns/1ps
module motor_startup_brake_config_chk
    import motor_cfg_pkg::*;
(
    // Clock and reset
    input logic sys_clk,
    input logic rst,
    // Register access port
    input logic reg_wr,
    input logic reg_rd,
    input logic [7:0] reg_addr,
    input logic [15:0] reg_rdata,
    input logic reg_ack,
    // Events
    input logic seq_start,
    input logic zero_cross,
    input logic brake_request,
    // Settings and status
    input logic [10:0] openloop_current_ma,
    input logic [10:0] align_current_ma,
    input logic [11:0] brake_time_ms,
    input logic brake_active_flag,
    input logic reverse_drive_enable,
    input logic rotor_stopped,
    input logic braking,
    input logic brake_done
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_ack; reg_ack == $past(reg_wr || reg_rd); endproperty
    a_ack: assert property (p_ack) else $error("ack timing");
    property p_hold; !$past(reg_rd) |-> $stable(reg_rdata); endproperty
    a_hold: assert property (p_hold) else $error("rdata moved");
    property p_top;
        $past(reg_rd) && $past(reg_addr) == 8'h93 |-> !reg_rdata[15];
    endproperty
    a_top: assert property (p_top) else $error("bit 15 set");
    property p_unmap;
        $past(reg_rd) && $past(reg_addr) != 8'h92 && $past(reg_addr) != 8'h93
            |-> reg_rdata == 16'h0000;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped data");
    property p_flag;
        brake_active_flag == (brake_time_ms != 12'h000);
    endproperty
    a_flag: assert property (p_flag) else $error("brake flag");
    property p_pair;
        {2'h0, openloop_current_ma} * 13'h0003 ==
            {2'h0, align_current_ma} * 13'h0004;
    endproperty
    a_pair: assert property (p_pair) else $error("align pairing");
    property p_bstart;
        brake_request && !braking && brake_active_flag |=> braking;
    endproperty
    a_bstart: assert property (p_bstart) else $error("brake start");
    property p_bdone;
        brake_done |-> $fell(braking) ##1 !brake_done;
    endproperty
    a_bdone: assert property (p_bdone) else $error("brake end");
    property p_rev; $changed(reverse_drive_enable) |-> $past(seq_start, 2);
    endproperty
    a_rev: assert property (p_rev) else $error("enable applied early");
    property p_zc; zero_cross |=> !rotor_stopped; endproperty
    a_zc: assert property (p_zc) else $error("stop not cleared");
endmodule : motor_startup_brake_config_chk

bind motor_startup_brake_config motor_startup_brake_config_chk i_chk (
    .sys_clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_rdata, .reg_ack,
    .seq_start, .zero_cross, .brake_request, .openloop_current_ma,
    .align_current_ma, .brake_time_ms, .brake_active_flag,
    .reverse_drive_enable, .rotor_stopped, .braking, .brake_done
);

// File: tb/motor_startup_brake_config_tb.sv
// Self-checking bench for the start-up and brake configuration block
`timescale 1ns/1ps
module motor_startup_brake_config_tb;
    import motor_cfg_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic seq_start = 1'b0;
    logic zero_cross = 1'b0;
    logic brake_request = 1'b0;
    logic [15:0] reg_rdata;
    logic reg_ack, speed_detect_enable, reverse_drive_enable;
    logic brake_active_flag, accel_range_select, rotor_stopped;
    logic braking, brake_done;
    logic [11:0] stationary_ms, stationary_chz, brake_time_ms;
    logic [5:0] brake_current_ma, backemf_hysteresis_mv;
    logic [8:0] reverse_threshold_dhz;
    logic [10:0] openloop_current_ma, align_current_ma;
    logic [12:0] openloop_current_ramp;
    logic [11:0] sms [4] = '{12'h050, 12'h0A0, 12'h140, 12'h280};
    logic [10:0] olt [4] = '{11'h0C8, 11'h190, 11'h320, 11'h640};
    logic [11:0] bms [8] = '{12'h000, 12'hA8C, 12'h514, 12'h29E,
                             12'h14A, 12'h0A0, 12'h050, 12'h028};
    int fail_count = 0;
    int cmp_count = 0;

    motor_startup_brake_config #(.MS_CYCLES(4)) i_dut (
        .sys_clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .reg_ack, .seq_start, .zero_cross, .brake_request, .stationary_ms,
        .stationary_chz, .brake_current_ma, .backemf_hysteresis_mv,
        .speed_detect_enable, .reverse_drive_enable, .reverse_threshold_dhz,
        .openloop_current_ma, .align_current_ma, .openloop_current_ramp,
        .brake_time_ms, .brake_active_flag, .accel_range_select,
        .rotor_stopped, .braking, .brake_done
    );

    initial
    begin
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test

    task automatic acc(input logic wr, input logic [7:0] a,
                       input logic [15:0] d);
        @(negedge sys_clk);
        reg_wr = wr;
        reg_rd = !wr;
        reg_addr = a;
        reg_wdata = d;
        @(negedge sys_clk);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        chk(16'(reg_ack), 16'h0001);
    endtask : acc

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        acc(1'b0, a, 16'h0000);
        chk(reg_rdata, exp);
    endtask : rd

    task automatic apply;
        @(negedge sys_clk);
        seq_start = 1'b1;
        @(negedge sys_clk);
        seq_start = 1'b0;
        repeat (2) @(negedge sys_clk);
    endtask : apply

    // Waits for rotor_stopped (1) or brake_done (0), returns cycles taken
    task automatic wait_bit(input logic sel, output int n);
        n = 0;
        while ((sel ? rotor_stopped : brake_done) !== 1'b1 && n < 1000)
        begin
            @(negedge sys_clk);
            n++;
        end
    endtask : wait_bit

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        end_of_test();
    end

    initial
    begin
        logic [2:0] c;
        logic [15:0] d;
        logic [1:0] k;
        int n;
        repeat (12) @(negedge sys_clk);
        rst = 1'b0;
        chk(16'(stationary_ms), 16'h0050);
        chk(16'(brake_active_flag), 16'h0000);
        rd(ADDR_STARTUP_BRAKE, 16'h0000);
        rd(8'h93, 16'h0000);
        acc(1'b1, 8'h93, 16'h7FFF);
        rd(8'h93, 16'h7FFF);
        acc(1'b1, 8'h94, 16'hFFFF);
        rd(8'h94, 16'h0000);
        for (int i = 0; i < 8; i++)
        begin
            c = 3'(i);
            k = c[1:0];
            d = {c[1:0], c[0], c[1], c[0], c[1], c[1:0], c[1:0], c, c};
            acc(1'b1, 8'h92, d);
            rd(8'h92, d);
            apply();
            chk(16'(stationary_ms), 16'(sms[c[1:0]]));
            chk(16'(stationary_chz), 16'(STAT_CHZ_TABLE[c[1:0]]));
            chk(16'(brake_current_ma), c[0] ? 16'h0030 : 16'h0018);
            chk(16'(backemf_hysteresis_mv), c[1] ? 16'h0028 : 16'h0014);
            chk(16'(speed_detect_enable), 16'(c[0]));
            chk(16'(reverse_drive_enable), 16'(c[1]));
            chk(16'(reverse_threshold_dhz), 16'(REV_THR_DHZ_TABLE[k]));
            chk(16'(openloop_current_ma), 16'(olt[c[1:0]]));
            chk(16'(align_current_ma), 16'(ALIGN_CUR_MA_TABLE[c[1:0]]));
            chk(16'(openloop_current_ramp), 16'(RAMP_TABLE[c]));
            chk(16'(brake_time_ms), 16'(bms[c]));
            chk(16'(brake_active_flag), 16'(c != 3'h0));
        end
        @(negedge sys_clk);
        brake_request = 1'b1;
        @(negedge sys_clk);
        brake_request = 1'b0;
        chk(16'(braking), 16'h0001);
        wait_bit(1'b0, n);
        chk(16'(n >= 156 && n <= 166), 16'h0001);
        chk(16'(braking), 16'h0000);
        acc(1'b1, 8'h92, 16'h0000);
        chk(16'(brake_time_ms), 16'h0028);
        apply();
        chk(16'(brake_active_flag), 16'h0000);
        @(negedge sys_clk);
        brake_request = 1'b1;
        @(negedge sys_clk);
        brake_request = 1'b0;
        @(negedge sys_clk);
        chk(16'(braking), 16'h0000);
        zero_cross = 1'b1;
        @(negedge sys_clk);
        zero_cross = 1'b0;
        wait_bit(1'b1, n);
        chk(16'(n >= 316 && n <= 326), 16'h0001);
        zero_cross = 1'b1;
        @(negedge sys_clk);
        zero_cross = 1'b0;
        @(negedge sys_clk);
        chk(16'(rotor_stopped), 16'h0000);
        acc(1'b1, 8'h93, 16'h0000);
        apply();
        chk(16'(accel_range_select), 16'h0000);
        acc(1'b1, 8'h93, 16'h4000);
        apply();
        chk(16'(accel_range_select), 16'h0001);
        end_of_test();
    end
endmodule : motor_startup_brake_config_tb
